// [core/embedded_ram_block.sv]
// Embedded RAM block: 4,096 bits in four aspect ratios, single or dual port,
// ROM preload, bypassable registers, AHB-Lite slave for configuration.
// Assumes user logic on ref_clk_in drives the section ticks and enables.
`include "ram_block_cfg.svh"

module embedded_ram_block
  import ram_block_pkg::*;
(
  input  wire logic                           ref_clk_in,
  input  wire logic                           rst_in,
  input  wire logic                           local_clr_in,
  input  wire logic                           global_clr_in,
  input  wire logic                           hsel_in,
  input  wire logic [31:0]                    haddr_in,
  input  wire logic [1:0]                     htrans_in,
  input  wire logic                           hwrite_in,
  input  wire logic [2:0]                     hsize_in,
  input  wire logic [31:0]                    hwdata_in,
  input  wire logic                           hready_in,
  output logic                                hreadyout_out,
  output logic                                hresp_out,
  output logic [31:0]                         hrdata_out,
  input  wire logic                           wr_tick_in,
  input  wire logic                           wr_ce_in,
  input  wire logic                           rd_tick_in,
  input  wire logic                           rd_ce_in,
  input  wire ram_block_pkg::port_req_t       wr_req_in,
  input  wire logic [`RB_ADDR_BITS-1:0]       rd_addr_in,
  input  wire logic                           rd_en_in,
  output logic [`RB_ROW_BITS-1:0]             rd_data_out
);
  import ram_block_pkg::*;

  logic [`RB_ROW_BITS-1:0]      mem_ff [`RB_ROWS];
  ctrl_t                        ctrl_ff;
  ahb_phase_t                   ap_ff;
  logic [`RB_ROW_ADDR_BITS-1:0] cfg_addr_ff;
  logic [15:0]                  wr_count_ff;
  logic                         hreadyout_ff;
  logic                         hresp_ff;
  logic [31:0]                  hrdata_ff;
  logic [`RB_ROW_BITS-1:0]      rd_data_ff;
  port_req_t                    wr_ff;
  logic [`RB_ADDR_BITS-1:0]     rd_addr_ff;
  logic                         rd_en_ff;

  logic                         clr_any;
  logic                         in_tick;
  logic                         rd_in_tick;
  logic                         out_tick;
  port_req_t                    wr_eff;
  logic [`RB_ADDR_BITS-1:0]     rd_addr_eff;
  logic                         rd_en_eff;
  logic                         user_wr;
  logic                         accept;
  logic                         dp_wr;
  logic [`RB_ROW_BITS-1:0]      rd_word;

  // Row index of a word address for a given organisation
  function automatic logic [`RB_ROW_ADDR_BITS-1:0] row_of(
    input logic [`RB_ADDR_BITS-1:0] a,
    input logic [1:0]               m
  );
    logic [`RB_ADDR_BITS-1:0] s;
    s = a >> m;
    return s[`RB_ROW_ADDR_BITS-1:0];
  endfunction

  // Bit offset of the addressed lane inside its row
  function automatic logic [3:0] lane_shift(
    input logic [`RB_ADDR_BITS-1:0] a,
    input logic [1:0]               m
  );
    logic [3:0] sh;
    sh = 4'h0;
    unique case (m)
      `RB_MODE_256X16:  sh = 4'h0;
      `RB_MODE_512X8:   sh = {a[0], 3'b000};
      `RB_MODE_1024X4:  sh = {a[1:0], 2'b00};
      `RB_MODE_2048X2:  sh = {a[2:0], 1'b0};
    endcase
    return sh;
  endfunction

  function automatic logic [`RB_ROW_BITS-1:0] lane_mask(input logic [1:0] m);
    logic [`RB_ROW_BITS-1:0] mk;
    mk = 16'hFFFF;
    unique case (m)
      `RB_MODE_256X16:  mk = 16'hFFFF;
      `RB_MODE_512X8:   mk = 16'h00FF;
      `RB_MODE_1024X4:  mk = 16'h000F;
      `RB_MODE_2048X2:  mk = 16'h0003;
    endcase
    return mk;
  endfunction

  // Clears arrive from user logic; the OR is glitch-prone, so drive them from flops
  assign clr_any = local_clr_in | global_clr_in;

  assign in_tick    = wr_tick_in & wr_ce_in;
  assign out_tick   = rd_tick_in & rd_ce_in;
  assign rd_in_tick = ctrl_ff.io_scheme ? in_tick : out_tick;

  // Each path takes either the pin or its register; the single-port read address takes the write address
  always_comb begin
    wr_eff.data = ctrl_ff.bypass[`RB_BYP_WDATA] ? wr_req_in.data : wr_ff.data;
    wr_eff.addr = ctrl_ff.bypass[`RB_BYP_WADDR] ? wr_req_in.addr : wr_ff.addr;
    wr_eff.en   = ctrl_ff.bypass[`RB_BYP_WE]    ? wr_req_in.en   : wr_ff.en;
    rd_en_eff   = ctrl_ff.bypass[`RB_BYP_RE]    ? rd_en_in       : rd_en_ff;
    if (ctrl_ff.dual) begin
      rd_addr_eff = ctrl_ff.bypass[`RB_BYP_RADDR] ? rd_addr_in : rd_addr_ff;
    end else begin
      rd_addr_eff = wr_eff.addr;
    end
  end

  // Internal write strobe, timed from the write tick; blocked in ROM mode
  assign user_wr = in_tick & wr_eff.en & ~ctrl_ff.rom;

  // Old row content is read here; same-edge write lands only afterwards
  assign rd_word = (mem_ff[row_of(rd_addr_eff, ctrl_ff.mode)]
                    >> lane_shift(rd_addr_eff, ctrl_ff.mode))
                   & lane_mask(ctrl_ff.mode);

  assign accept = hsel_in & htrans_in[1] & hready_in;
  assign dp_wr  = ap_ff.valid & ap_ff.write;

  // Input-side registers
  always_ff @(posedge ref_clk_in or posedge clr_any) begin
    if (clr_any) begin
      wr_ff <= '0;
    end else if (rst_in) begin
      wr_ff <= '0;
    end else if (in_tick) begin
      wr_ff <= wr_req_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge clr_any) begin
    if (clr_any) begin
      rd_addr_ff <= '0;
      rd_en_ff   <= 1'b0;
    end else if (rst_in) begin
      rd_addr_ff <= '0;
      rd_en_ff   <= 1'b0;
    end else if (rd_in_tick) begin
      rd_addr_ff <= rd_addr_in;
      rd_en_ff   <= rd_en_in;
    end
  end

  // Bypassed output still passes a flop, updating every clock instead of per tick
  always_ff @(posedge ref_clk_in or posedge clr_any) begin
    if (clr_any) begin
      rd_data_ff <= '0;
    end else if (rst_in) begin
      rd_data_ff <= '0;
    end else if (rd_en_eff && (ctrl_ff.bypass[`RB_BYP_DOUT] || out_tick)) begin
      rd_data_ff <= rd_word;
    end
  end

  // Storage: bus preload wins over a user write in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (dp_wr && ap_ff.addr == `RB_OFF_CFG_DATA) begin
      mem_ff[cfg_addr_ff] <= hwdata_in[`RB_ROW_BITS-1:0];
    end else if (user_wr) begin
      mem_ff[row_of(wr_eff.addr, ctrl_ff.mode)] <=
        (mem_ff[row_of(wr_eff.addr, ctrl_ff.mode)]
         & ~(lane_mask(ctrl_ff.mode) << lane_shift(wr_eff.addr, ctrl_ff.mode)))
        | ((wr_eff.data & lane_mask(ctrl_ff.mode))
           << lane_shift(wr_eff.addr, ctrl_ff.mode));
    end
  end

  // Bus address phase; reads get one wait state so pending writes settle first
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ap_ff        <= '0;
      hreadyout_ff <= 1'b1;
    end else begin
      if (hready_in) begin
        ap_ff.valid <= accept;
        ap_ff.write <= hwrite_in;
        ap_ff.addr  <= haddr_in[7:0];
      end
      hreadyout_ff <= !(accept && !hwrite_in);
    end
  end

  // No error responses exist; kept in a flop so every output is registered
  always_ff @(posedge ref_clk_in) begin
    hresp_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (ap_ff.valid && !ap_ff.write && !hreadyout_ff) begin
      unique case (ap_ff.addr)
        `RB_OFF_CTRL:     hrdata_ff <= {21'h0, ctrl_ff};
        `RB_OFF_CFG_ADDR: hrdata_ff <= {24'h0, cfg_addr_ff};
        `RB_OFF_CFG_DATA: hrdata_ff <= {16'h0, mem_ff[cfg_addr_ff]};
        `RB_OFF_STATUS:   hrdata_ff <= {16'h0, wr_count_ff};
        default:          hrdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_ff <= ctrl_t'(`RB_CTRL_RESET);
    end else if (dp_wr && ap_ff.addr == `RB_OFF_CTRL) begin
      ctrl_ff <= ctrl_t'(hwdata_in[`RB_CTRL_BITS-1:0]);
    end
  end

  // Preload pointer steps after each data word
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cfg_addr_ff <= '0;
    end else if (dp_wr && ap_ff.addr == `RB_OFF_CFG_ADDR) begin
      cfg_addr_ff <= hwdata_in[`RB_ROW_ADDR_BITS-1:0];
    end else if (dp_wr && ap_ff.addr == `RB_OFF_CFG_DATA) begin
      cfg_addr_ff <= cfg_addr_ff + 8'h01;
    end
  end

  // Count of user writes; a write in the clearing cycle still counts
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_count_ff <= 16'h0000;
    end else if (dp_wr && ap_ff.addr == `RB_OFF_STATUS) begin
      wr_count_ff <= {15'h0000, user_wr};
    end else if (user_wr) begin
      wr_count_ff <= wr_count_ff + 16'h0001;
    end
  end

  assign hreadyout_out = hreadyout_ff;
  assign hresp_out     = hresp_ff;
  assign hrdata_out    = hrdata_ff;
  assign rd_data_out   = rd_data_ff;

endmodule

// [core/ram_block_cfg.svh]
// Constants for the embedded RAM block: register offsets, reset values, sizes.
// Included by the package and the block; definitions only.
`ifndef RAM_BLOCK_CFG_SVH
`define RAM_BLOCK_CFG_SVH

`define RB_TOTAL_BITS     4096
`define RB_ROWS           256
`define RB_ROW_BITS       16
`define RB_ADDR_BITS      11
`define RB_ROW_ADDR_BITS  8

`define RB_MODE_256X16    2'h0
`define RB_MODE_512X8     2'h1
`define RB_MODE_1024X4    2'h2
`define RB_MODE_2048X2    2'h3

`define RB_BYP_WDATA      0
`define RB_BYP_DOUT       1
`define RB_BYP_WADDR      2
`define RB_BYP_WE         3
`define RB_BYP_RADDR      4
`define RB_BYP_RE         5

`define RB_OFF_CTRL       8'h00
`define RB_OFF_CFG_ADDR   8'h04
`define RB_OFF_CFG_DATA   8'h08
`define RB_OFF_STATUS     8'h0C

`define RB_CTRL_RESET     11'h000
`define RB_CTRL_BITS      11

`endif

// [core/ram_block_pkg.sv]
// Types shared by the embedded RAM block and its bench.
// Assumes ram_block_cfg.svh sits on the include path.
`include "ram_block_cfg.svh"

package ram_block_pkg;

  // Control register layout, bit 10 down to bit 0
  typedef struct packed {
    logic [5:0] bypass;
    logic       rom;
    logic       io_scheme;
    logic       dual;
    logic [1:0] mode;
  } ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } ahb_phase_t;

  typedef struct packed {
    logic [`RB_ADDR_BITS-1:0] addr;
    logic [`RB_ROW_BITS-1:0]  data;
    logic                     en;
  } port_req_t;

endpackage

// [testbench/configurable_embedded_ram_block_bench.sv]
// Self-checking bench for the embedded RAM block.
// Assumes package, block, checker and user-side model compiled before it.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module configurable_embedded_ram_block_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ram_block_pkg::*;
  localparam logic [31:0] Z = 32'h0000_0000;
  logic        ref_clk_in = 1'b0, rst_in = 1'b1, lclr = 1'b0, gclr = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0, hready, hresp, wt, wc, rt, rc, re;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = Z, hwdata = Z, hrdata, r;
  port_req_t   wreq;
  logic [10:0] raddr;
  logic [15:0] rdata, q;
  int          fail_count = 0, comparisons = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  embedded_ram_block embedded_ram_block_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .local_clr_in(lclr), .global_clr_in(gclr), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
    .wr_tick_in(wt), .wr_ce_in(wc), .rd_tick_in(rt), .rd_ce_in(rc), .wr_req_in(wreq),
    .rd_addr_in(raddr), .rd_en_in(re), .rd_data_out(rdata));
  user_side_model user_side_model_i (.clk_in(ref_clk_in), .rd_data_in(rdata),
    .wr_tick_out(wt), .wr_ce_out(wc), .rd_tick_out(rt), .rd_ce_out(rc),
    .wr_req_out(wreq), .rd_addr_out(raddr), .rd_en_out(re));
  // Dual-port, every register bypassed
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic rom);
    return {21'h00_0000, 6'h3F, rom, 1'b0, 1'b1, m};
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk_in); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic t_regs;
    bus(1'b0, 8'h00, Z);
    `CHK(r, Z)
    bus(1'b1, 8'h00, ctl(2'h1, 1'b0));
    bus(1'b0, 8'h00, Z);
    `CHK(r, ctl(2'h1, 1'b0))
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    bus(1'b0, 8'h10, Z);
    `CHK(r, Z)
    $display("t_regs done");
  endtask
  task automatic t_modes;
    logic [10:0] a;
    logic [15:0] m;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, ctl(i[1:0], 1'b0));
      a = 11'((256 << i) - 2);
      m = 16'hFFFF >> (16 - (16 >> i));
      user_side_model_i.wr(a, 16'h5A96, 1'b1);
      user_side_model_i.wr(a + 11'h001, 16'hC3E1, 1'b1);
      user_side_model_i.rd(a, q);
      `CHK(q, 16'h5A96 & m)
      user_side_model_i.rd(a + 11'h001, q);
      `CHK(q, 16'hC3E1 & m)
    end
    user_side_model_i.wr(a, 16'h0000, 1'b0);
    user_side_model_i.rd(a, q);
    `CHK(q, 16'h0002)
    $display("t_modes done");
  endtask
  task automatic t_same;
    bus(1'b1, 8'h00, ctl(2'h0, 1'b0));
    user_side_model_i.wr(11'h003, 16'h1111, 1'b1);
    fork
      user_side_model_i.wr(11'h003, 16'h2222, 1'b1);
      user_side_model_i.rd(11'h003, q);
    join
    `CHK(q, 16'h1111)
    user_side_model_i.rd(11'h003, q);
    `CHK(q, 16'h2222)
    $display("t_same done");
  endtask
  task automatic t_rom;
    bus(1'b1, 8'h04, 32'h0000_0010);
    bus(1'b1, 8'h08, 32'h0000_A5C3);
    bus(1'b1, 8'h08, 32'h0000_3C5A);
    bus(1'b1, 8'h00, ctl(2'h0, 1'b1));
    user_side_model_i.wr(11'h010, 16'hFFFF, 1'b1);
    user_side_model_i.rd(11'h010, q);
    `CHK(q, 16'hA5C3)
    user_side_model_i.rd(11'h011, q);
    `CHK(q, 16'h3C5A)
    $display("t_rom done");
  endtask
  task automatic t_clear;
    for (int k = 0; k < 2; k++) begin
      user_side_model_i.rd(11'h011, q);
      @(posedge ref_clk_in);
      lclr <= (k == 0);
      gclr <= (k == 1);
      @(negedge ref_clk_in);
      `CHK(rdata, 16'h0000)
      @(posedge ref_clk_in);
      lclr <= 1'b0;
      gclr <= 1'b0;
    end
    $display("t_clear done");
  endtask
  // Single-port, output register in, other paths bypassed; read follows write address
  task automatic t_single;
    bus(1'b1, 8'h00, 32'h0000_07A0);
    bus(1'b1, 8'h0C, Z);
    user_side_model_i.wr(11'h005, 16'hABCD, 1'b1);
    fork
      user_side_model_i.wr(11'h005, 16'h0000, 1'b0);
      user_side_model_i.rd(11'h7FF, q);
    join
    `CHK(q, 16'hABCD)
    bus(1'b0, 8'h0C, Z);
    `CHK(r, 32'h0000_0001)
    $display("t_single done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_modes;
    t_same;
    t_rom;
    t_clear;
    t_single;
    end_sim;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fail_count++;
    end_sim;
  end
endmodule

// [testbench/ram_block_sva.sv]
// Checker for the RAM block's bus handshake and read word.
// Bound into embedded_ram_block; sees its ports only.
module ram_block_sva (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic        local_clr_in,
  input wire logic        global_clr_in,
  input wire logic        hsel_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic [15:0] rd_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic rd_take;
  logic wr_take;
  assign rd_take = hsel_in & htrans_in[1] & hready_in & !hwrite_in;
  assign wr_take = hsel_in & htrans_in[1] & hready_in & hwrite_in;
  a_resp_okay: assert property (hresp_out == 1'b0) else $error("response not okay");
  a_read_wait: assert property (rd_take |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read not one wait state");
  a_write_nowait: assert property (wr_take |=> hreadyout_out) else $error("write stalled");
  a_wait_cause: assert property ($fell(hreadyout_out) |-> $past(rd_take))
    else $error("wait without read");
  a_wait_single: assert property (!hreadyout_out |=> hreadyout_out) else $error("long wait");
  a_rdata_hold: assert property ($changed(hrdata_out) && !$past(rst_in)
    |-> $past(rd_take) || $rose(hreadyout_out)) else $error("read data moved");
  a_clear_word: assert property (local_clr_in || global_clr_in |-> rd_data_out == 16'h0000)
    else $error("read word not cleared");
  a_reset_state: assert property (disable iff (1'b0) rst_in |=> hreadyout_out
    && hrdata_out == 32'h0000_0000 && rd_data_out == 16'h0000) else $error("bad reset");
  c_read: cover property (rd_take);
  c_write: cover property (wr_take);
  c_clear: cover property (global_clr_in);
  c_word: cover property ($changed(rd_data_out));
endmodule

bind embedded_ram_block ram_block_sva ram_block_sva_i (.ref_clk_in(ref_clk_in),
  .rst_in(rst_in), .local_clr_in(local_clr_in), .global_clr_in(global_clr_in),
  .hsel_in(hsel_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
  .rd_data_out(rd_data_out));

// [testbench/user_side_model.sv]
// Model of the user logic driving the write and read sections.
// Assumes one clock; section ticks are one-cycle strobes on it.
module user_side_model
  import ram_block_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic [15:0]         rd_data_in,
  output logic                     wr_tick_out,
  output logic                     wr_ce_out,
  output logic                     rd_tick_out,
  output logic                     rd_ce_out,
  output ram_block_pkg::port_req_t wr_req_out,
  output logic [10:0]              rd_addr_out,
  output logic                     rd_en_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {wr_tick_out, wr_ce_out, rd_tick_out, rd_ce_out, rd_en_out} = 5'h00;
    wr_req_out = '0;
    rd_addr_out = 11'h000;
  end
  // One write section only; a second write path needs a second block
  // One block only: a wider word would take a second block on these addresses
  // Addresses stay inside one block's 11 bits; deeper needs outside decoding
  task automatic wr(input logic [10:0] a, input logic [15:0] d, input logic ce);
    @(posedge clk_in);
    wr_req_out <= '{addr: a, data: d, en: 1'b1};
    wr_tick_out <= 1'b1;
    wr_ce_out <= ce;
    @(posedge clk_in);
    // Released lines show the inverse, never a stale copy
    wr_req_out <= port_req_t'(~wr_req_out);
    wr_tick_out <= 1'b0;
    wr_ce_out <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [15:0] q);
    @(posedge clk_in);
    rd_addr_out <= a;
    rd_en_out <= 1'b1;
    rd_tick_out <= 1'b1;
    rd_ce_out <= 1'b1;
    @(posedge clk_in);
    rd_addr_out <= ~rd_addr_out;
    rd_en_out <= 1'b0;
    rd_tick_out <= 1'b0;
    rd_ce_out <= 1'b0;
    @(negedge clk_in);
    q = rd_data_in;
  endtask
endmodule
